// ### rom_interface_controller.sv
// ROM interface controller: chip select, latched address, half-word assembly, bank configuration
// Overview of operation
// - Chip select is asserted only for addresses 0x00000000 to 0x01FFFFFF.
// - Writes to the ROM region never assert the chip select.
// - Config bit 5 clear doubles every access time; set leaves the counts unchanged.
// - Burst reads step bits 3:2 of the latched address, up to four reads.
// - Config bit 6 clear selects a 32-bit bank, set selects a 16-bit bank.
// - A 16-bit bank without burst does two non-sequential fetches and joins them into one word.
// - A 16-bit bank with burst does the first half non-sequential and the second as a burst cycle.
// - In a 16-bit bank the address is shifted up one so its low bit appears on line 2.
// - The half word at the lower ROM address forms the low 16 bits of the returned word.
// - Both configuration registers reset to 0x40.
// - Byte writes at 0x03200080 and 0x03200084 program bank 0 and bank 1 configuration.
// - Non-sequential codes 000 to 101 give 7 down to 2 cycles at normal speed.
// - Burst code 00 is off, and 01, 10, 11 give 4, 3, 2 cycles at normal speed.
// - Reading a configuration register returns the fields last written.
module rom_interface_controller
  import rom_pkg::*;
#(
  parameter int ADDR_WIDTH = 29
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  access_request,
  input  wire logic                  access_write,
  input  wire logic                  access_sequential,
  input  wire logic [31:0]           access_address,
  input  wire logic [7:0]            access_write_data,
  output logic                       access_done,
  output logic      [31:0]           access_read_data,
  output logic                       rom_select_n,
  output logic      [ADDR_WIDTH-1:0] latched_address_bus,
  input  wire logic [31:0]           rom_data
);
  // Below 26 lines a 16-bit bank cannot reach the whole region; above 32 the word address runs out
  if (ADDR_WIDTH < 26 || ADDR_WIDTH > 32) begin : g_width_check
    $error("ADDR_WIDTH must lie between 26 and 32");
  end

  logic [7:0]      bank0_config_reg;
  logic [7:0]      bank1_config_reg;
  rom_state_t      state_reg;
  logic [4:0]      count_reg;
  logic            half_reg;
  logic            burst_phase_reg;
  logic [1:0]      burst_offset_reg;
  logic [15:0]     low_half_reg;
  logic [31:0]     word_reg;
  logic [7:0]      active_config_reg;
  logic [4:0]      cycles;
  logic            burst_enabled;
  logic            in_rom;
  logic            rom_read;
  logic            config_hit0;
  logic            config_hit1;
  logic            wide16;
  logic [29:0]     word_address;
  logic [7:0]      request_config;

  assign in_rom       = access_address <= ROM_REGION_LAST;
  assign rom_read     = access_request && in_rom && !access_write;
  assign config_hit0  = access_address == ROM_BANK0_CONFIG_ADDR;
  assign config_hit1  = access_address == ROM_BANK1_CONFIG_ADDR;
  assign wide16       = active_config_reg[ROM_WIDTH_BIT];
  assign request_config = access_address[ROM_BANK_SELECT_BIT] ? bank1_config_reg : bank0_config_reg;

  rom_timing u_timing (
    .config_value  (active_config_reg),
    .burst_phase   (burst_phase_reg),
    .cycles        (cycles),
    .burst_enabled (burst_enabled)
  );

  // Configuration registers take byte writes at their own addresses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank0_config_reg <= ROM_CONFIG_RESET;
      bank1_config_reg <= ROM_CONFIG_RESET;
    end else if (access_request && access_write && state_reg == ROM_IDLE) begin
      if (config_hit0) begin
        bank0_config_reg <= {1'h0, access_write_data[6:0]};
      end
      if (config_hit1) begin
        bank1_config_reg <= {1'h0, access_write_data[6:0]};
      end
    end
  end

  // Burst offset steps within the quad word; a non-sequential access restarts it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg         <= ROM_IDLE;
      count_reg         <= 5'h0;
      half_reg          <= 1'b0;
      burst_phase_reg   <= 1'b0;
      burst_offset_reg  <= 2'h0;
      word_address      <= 30'h0;
      active_config_reg <= ROM_CONFIG_RESET;
    end else begin
      unique case (state_reg)
        ROM_IDLE: begin
          if (rom_read) begin
            active_config_reg <= request_config;
            word_address      <= access_address[31:2];
            half_reg          <= 1'b0;
            // Sequential hit in the same quad word of a 32-bit burst bank goes straight to burst timing
            burst_phase_reg   <= access_sequential && (request_config[ROM_BURST_LSB +: 2] != 2'h0)
                                 && !request_config[ROM_WIDTH_BIT]
                                 && access_address[3:2] != 2'h0
                                 && access_address[3:2] == burst_offset_reg + 2'h1;
            burst_offset_reg  <= access_address[3:2];
            state_reg         <= ROM_FIRST;
          end
        end
        ROM_FIRST: begin
          count_reg <= cycles - 5'h1;
          state_reg <= ROM_WAIT;
        end
        ROM_WAIT: begin
          if (count_reg != 5'h0) begin
            count_reg <= count_reg - 5'h1;
          end else if (wide16 && !half_reg) begin
            half_reg        <= 1'b1;
            burst_phase_reg <= burst_enabled;
            state_reg       <= ROM_FIRST;
          end else begin
            state_reg <= ROM_DONE;
          end
        end
        ROM_DONE: begin
          state_reg <= ROM_IDLE;
        end
      endcase
    end
  end

  // Data capture: lower ROM address supplies the low half
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_half_reg <= 16'h0;
      word_reg     <= 32'h0;
    end else if (state_reg == ROM_WAIT && count_reg == 5'h0) begin
      if (!wide16) begin
        word_reg <= rom_data;
      end else if (!half_reg) begin
        low_half_reg <= rom_data[15:0];
      end else begin
        word_reg <= {rom_data[15:0], low_half_reg};
      end
    end
  end

  always_comb begin
    if (wide16) begin
      latched_address_bus = ADDR_WIDTH'({word_address[ADDR_WIDTH-3:0], half_reg, 2'h0});
    end else begin
      latched_address_bus = ADDR_WIDTH'({word_address[ADDR_WIDTH-3:0], 2'h0});
    end
  end

  // Register reads answer immediately from the current byte values
  always_comb begin
    if (state_reg == ROM_DONE) begin
      access_read_data = word_reg;
    end else if (config_hit0) begin
      access_read_data = {24'h0, bank0_config_reg};
    end else begin
      access_read_data = {24'h0, bank1_config_reg};
    end
  end

  assign access_done  = (state_reg == ROM_DONE)
                        || (access_request && state_reg == ROM_IDLE && !rom_read);
  assign rom_select_n = !(state_reg == ROM_FIRST || state_reg == ROM_WAIT);

  AST_NO_WRITE_SELECT: assert property (@(posedge clock) disable iff (!rst_n)
    (access_request && access_write && state_reg == ROM_IDLE) |=> rom_select_n)
    else $error("chip select asserted for a write");
  AST_RESET_CONFIG: assert property (@(posedge clock)
    $rose(rst_n) |-> bank0_config_reg == ROM_CONFIG_RESET && bank1_config_reg == ROM_CONFIG_RESET)
    else $error("configuration reset value wrong");
  AST_WRITE_BANK0: assert property (@(posedge clock) disable iff (!rst_n)
    (access_request && access_write && config_hit0 && state_reg == ROM_IDLE)
    |=> bank0_config_reg[6:0] == $past(access_write_data[6:0]))
    else $error("bank 0 configuration not written");
  AST_OUT_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    (access_request && state_reg == ROM_IDLE && access_address > ROM_REGION_LAST) |=> rom_select_n)
    else $error("chip select outside ROM range");
  AST_SLOW_32: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ROM_FIRST && !burst_phase_reg && active_config_reg[7:0] == 8'h00)
    |=> count_reg == 5'hD)
    else $error("half speed count wrong");
  AST_FAST_NSEQ: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ROM_FIRST && !burst_phase_reg && active_config_reg == 8'h25) |=> count_reg == 5'h1)
    else $error("fastest non-sequential count wrong");
  AST_BURST_FAST: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ROM_FIRST && burst_phase_reg && active_config_reg[5:3] == 3'b111) |=> count_reg == 5'h1)
    else $error("fastest burst count wrong");
  AST_HALF_LINE2: assert property (@(posedge clock) disable iff (!rst_n)
    (wide16 && !rom_select_n) |-> latched_address_bus[2] == half_reg && latched_address_bus[1:0] == 2'h0)
    else $error("16-bit half address not on line 2");
  AST_SELECT_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    !rom_select_n |-> {word_address, 2'h0} <= ROM_REGION_LAST)
    else $error("chip select for an address outside the ROM region");
  AST_HALF_NSEQ: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ROM_WAIT && count_reg == 5'h0 && wide16 && !half_reg && !burst_enabled)
    |=> state_reg == ROM_FIRST && half_reg && !burst_phase_reg)
    else $error("16-bit second fetch not non-sequential");
  AST_HALF_BURST: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ROM_WAIT && count_reg == 5'h0 && wide16 && !half_reg && burst_enabled)
    |=> state_reg == ROM_FIRST && half_reg && burst_phase_reg)
    else $error("16-bit second fetch not a burst cycle");
  AST_BURST_SLOW: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ROM_FIRST && burst_phase_reg && active_config_reg[5:3] == 3'b101) |=> count_reg == 5'h3)
    else $error("slowest burst count wrong");
  AST_BURST_IN_QUAD: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ROM_FIRST && burst_phase_reg && !half_reg) |-> latched_address_bus[3:2] != 2'h0)
    else $error("burst timing used across a quad word boundary");
endmodule

// ### rom_model.sv
// Behavioural ROM device answering reads at the latched address
module rom_model (
  input  wire logic        clock,
  input  wire logic        rom_select_n,
  input  wire logic [28:0] latched_address_bus,
  output logic      [31:0] rom_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] half_word;
  logic [31:0] last_word = 32'h0000_0000;
  // Contents follow the word address only, so both bank widths index one array
  assign half_word = latched_address_bus[17:2] ^ {6'h00, latched_address_bus[28:19]} ^ 16'h3C5A;
  // Deselected, the bus shows the inverse of the last word so stale data never passes
  assign rom_data = rom_select_n ? ~last_word : {~half_word, half_word};
  always @(posedge clock) begin
    if (!rom_select_n) begin
      last_word <= rom_data;
    end
  end
endmodule

// ### rom_pkg.sv
// Constants shared by the ROM interface controller
package rom_pkg;
  localparam logic [31:0] ROM_BANK0_CONFIG_ADDR = 32'h0320_0080;
  localparam logic [31:0] ROM_BANK1_CONFIG_ADDR = 32'h0320_0084;
  localparam logic [31:0] ROM_REGION_LAST      = 32'h01FF_FFFF;
  localparam logic [7:0]  ROM_CONFIG_RESET     = 8'h40;
  localparam int          ROM_BANK_SELECT_BIT  = 24;
  localparam int          ROM_NSEQ_LSB         = 0;
  localparam int          ROM_BURST_LSB        = 3;
  localparam int          ROM_SPEED_BIT        = 5;
  localparam int          ROM_WIDTH_BIT        = 6;
  localparam logic [3:0]  ROM_NSEQ_SLOWEST     = 4'h7;
  localparam logic [3:0]  ROM_BURST_SLOWEST    = 4'h4;
  localparam logic [2:0]  ROM_NSEQ_FASTEST_CODE = 3'h5;

  typedef enum logic [1:0] {
    ROM_IDLE  = 2'b00,
    ROM_FIRST = 2'b01,
    ROM_WAIT  = 2'b10,
    ROM_DONE  = 2'b11
  } rom_state_t;
endpackage

// ### rom_timing.sv
// Converts configuration timing fields into memory clock cycle counts
module rom_timing
  import rom_pkg::*;
(
  input  wire logic [7:0] config_value,
  input  wire logic       burst_phase,
  output logic      [4:0] cycles,
  output logic            burst_enabled
);
  logic [2:0] nseq_code;
  logic [1:0] burst_code;
  logic [3:0] base;

  assign nseq_code     = config_value[ROM_NSEQ_LSB +: 3];
  assign burst_code    = config_value[ROM_BURST_LSB +: 2];
  assign burst_enabled = burst_code != 2'h0;

  always_comb begin
    if (burst_phase && burst_enabled) begin
      base = ROM_BURST_SLOWEST - {2'h0, burst_code} + 4'h1;
    end else if (nseq_code > ROM_NSEQ_FASTEST_CODE) begin
      base = 4'h2;
    end else begin
      base = ROM_NSEQ_SLOWEST - {1'h0, nseq_code};
    end
    cycles = config_value[ROM_SPEED_BIT] ? {1'h0, base} : {base, 1'h0};
  end
endmodule

// ### tb.sv
// Self-checking bench for the ROM interface controller against a behavioural ROM
module tb
  import rom_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        access_request = 1'b0;
  logic        access_write = 1'b0;
  logic        access_sequential = 1'b0;
  logic [31:0] access_address = 32'h0000_0000;
  logic [7:0]  access_write_data = 8'h00;
  logic        access_done;
  logic        rom_select_n;
  logic [31:0] access_read_data;
  logic [31:0] rom_data;
  logic [28:0] latched_address_bus;
  logic [31:0] got;
  logic [31:0] adr;
  logic [7:0]  cfg;
  int          err_count = 0;
  int          check_count = 0;
  int          seed = 9;
  int          lat;
  int          lat_ref;
  int          sel;
  int          i;
  int          b;
  always #20 clock = ~clock;
  rom_interface_controller i_dut (.clock(clock), .rst_n(rst_n), .access_request(access_request),
    .access_write(access_write), .access_sequential(access_sequential), .access_address(access_address),
    .access_write_data(access_write_data), .access_done(access_done), .access_read_data(access_read_data),
    .rom_select_n(rom_select_n), .latched_address_bus(latched_address_bus), .rom_data(rom_data));
  rom_model i_rom (.clock(clock), .rom_select_n(rom_select_n), .latched_address_bus(latched_address_bus),
    .rom_data(rom_data));
  function automatic logic [15:0] hw(logic [26:0] w);
    return w[15:0] ^ {6'h00, w[26:17]} ^ 16'h3C5A;
  endfunction
  // A 16-bit bank puts the lower half-word address in the low half of the result
  function automatic logic [31:0] exp_word(logic [31:0] a, logic wide);
    return wide ? {~hw(a[28:2]), hw(a[28:2])} : {hw({a[27:2], 1'b1}), hw({a[27:2], 1'b0})};
  endfunction
  // Memory clocks of one fetch from a configuration byte; reserved codes are not used here
  function automatic int rom_cycles(logic [7:0] c, logic brst);
    int n;
    n = brst ? 5 - int'(c[4:3]) : 7 - int'(c[2:0]);
    return c[5] ? n : 2 * n;
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Request held until completion is seen; select cycles and latency are counted
  task automatic acc(logic wr, logic sq, logic [31:0] a, logic [7:0] d);
    @(negedge clock);
    access_request = 1'b1;
    access_write = wr;
    access_sequential = sq;
    access_address = a;
    access_write_data = d;
    lat = 0;
    sel = 0;
    #1;
    while (access_done !== 1'b1) begin
      if (rom_select_n === 1'b0) sel++;
      lat++;
      if (lat > 200) begin
        err_count++;
        report_and_stop();
      end
      @(negedge clock);
      #1;
    end
    got = access_read_data;
    @(negedge clock);
    access_request = 1'b0;
    #1;
    if (rom_select_n === 1'b0) sel++;
  endtask
  task automatic rom_rd(logic [31:0] a, logic sq, logic wide);
    acc(1'b0, sq, a, 8'h00);
    chk("rom_word", got, exp_word(a, wide));
    chk("rom_select", 32'(sel > 0), 32'h1);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    acc(1'b0, 1'b0, ROM_BANK0_CONFIG_ADDR, 8'h00);
    chk("cfg0_reset", got[7:0], ROM_CONFIG_RESET);
    acc(1'b0, 1'b0, ROM_BANK1_CONFIG_ADDR, 8'h00);
    chk("cfg1_reset", got[7:0], ROM_CONFIG_RESET);
    for (i = 0; i < 4; i++) begin
      cfg = 8'($random(seed));
      acc(1'b1, 1'b0, i[0] ? ROM_BANK1_CONFIG_ADDR : ROM_BANK0_CONFIG_ADDR, cfg);
      acc(1'b0, 1'b0, i[0] ? ROM_BANK1_CONFIG_ADDR : ROM_BANK0_CONFIG_ADDR, 8'h00);
      chk("cfg_readback", got[7:0], {1'b0, cfg[6:0]});
    end
    for (i = 0; i < 6; i++) begin
      acc(1'b1, 1'b0, ROM_BANK0_CONFIG_ADDR, 8'h20 | 8'(i));
      adr = $random(seed) & 32'h00FF_FFFC;
      rom_rd(adr, 1'b0, 1'b1);
      if (i == 0) lat_ref = lat;
      chk("nseq_cycles", lat_ref - lat, i);
      chk("nseq_latency", lat, 2 + rom_cycles(8'h20 | 8'(i), 1'b0));
    end
    acc(1'b1, 1'b0, ROM_BANK0_CONFIG_ADDR, 8'h00);
    rom_rd(adr, 1'b0, 1'b1);
    chk("half_speed", lat - lat_ref, 7);
    chk("half_speed_latency", lat, 2 + rom_cycles(8'h00, 1'b0));
    for (b = 1; b < 4; b++) begin
      cfg = 8'h25 | 8'(b << 3);
      acc(1'b1, 1'b0, ROM_BANK0_CONFIG_ADDR, cfg);
      adr = $random(seed) & 32'h00FF_FFE0;
      rom_rd(adr, 1'b0, 1'b1);
      for (i = 1; i < 4; i++) rom_rd(adr + 32'(4 * i), 1'b1, 1'b1);
      if (b == 1) lat_ref = lat;
      chk("burst_cycles", lat_ref - lat, b - 1);
      chk("burst_latency", lat, 2 + rom_cycles(cfg, 1'b1));
      // Next quad word starts a new burst, so it takes non-sequential time
      rom_rd(adr + 32'h10, 1'b1, 1'b1);
      chk("burst_wrap_latency", lat, 2 + rom_cycles(cfg, 1'b0));
    end
    acc(1'b1, 1'b0, ROM_BANK1_CONFIG_ADDR, 8'h65);
    adr = 32'h0100_0000 | ($random(seed) & 32'h00FF_FFFC);
    rom_rd(adr, 1'b0, 1'b0);
    lat_ref = lat;
    chk("half_nseq_latency", lat, 3 + 2 * rom_cycles(8'h65, 1'b0));
    acc(1'b1, 1'b0, ROM_BANK1_CONFIG_ADDR, 8'h6D);
    rom_rd(adr, 1'b0, 1'b0);
    chk("half_burst", lat - lat_ref, 2);
    chk("half_burst_latency", lat, 3 + rom_cycles(8'h6D, 1'b0) + rom_cycles(8'h6D, 1'b1));
    rom_rd(adr & 32'h00FF_FFFC, 1'b0, 1'b1);
    rom_rd(32'h01FF_FFFC, 1'b0, 1'b0);
    acc(1'b0, 1'b0, 32'h0200_0000, 8'h00);
    chk("unmapped_select", sel, 0);
    acc(1'b1, 1'b0, 32'h0000_1000, 8'hA5);
    chk("write_select", sel, 0);
    // Reset in mid-run must bring bank 1 back to slow 16-bit operation
    @(negedge clock);
    rst_n = 1'b0;
    @(negedge clock);
    rst_n = 1'b1;
    acc(1'b0, 1'b0, ROM_BANK1_CONFIG_ADDR, 8'h00);
    chk("cfg1_rerun_reset", got[7:0], ROM_CONFIG_RESET);
    rom_rd(32'h0100_0000, 1'b0, 1'b0);
    chk("reset_latency", lat, 3 + 2 * rom_cycles(ROM_CONFIG_RESET, 1'b0));
    report_and_stop();
  end
endmodule
